/* File: pkg/ecd_map.vh */
`ifndef ECD_MAP_VH
`define ECD_MAP_VH
// Register byte offsets
`define ECD_CTRL_OFF 12'h000
`define ECD_STAT_OFF 12'h004
`define ECD_PEND_OFF 12'h008
// Control fields
`define ECD_CTRL_EN_BIT 0
`define ECD_CTRL_CLR_BIT 1
// Status fields
`define ECD_STAT_BUSY_BIT 0
`define ECD_STAT_PHASE_LSB 1
`define ECD_STAT_CODE_LSB 4
// Reset values
`define ECD_CTRL_RST 1'b1
// Machine cycle length in microseconds, and in clock cycles at 100 MHz
`define ECD_CYCLE_US 10000
`define ECD_CLK_MHZ 100
`define ECD_CYCLE_CLKS (`ECD_CYCLE_US * `ECD_CLK_MHZ)
// Cycles appended after an input
`define ECD_EXTRA_CYCLES 3
`endif

/* File: core/ecd_sync.v */
`timescale 1ns/1ns
// Two-stage synchroniser for a bus of pin inputs
module ecd_sync #(
  parameter W = 15
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Asynchronous data in, synchronised data out
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff; // First stage, read only by the second
  reg [W-1:0] sync_ff; // Second stage
  // Shift through two flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
  assign q = sync_ff;
endmodule

/* File: core/ecd_top.v */
`timescale 1ns/1ns
`include "ecd_map.vh"
module ecd_top #(
  parameter CH = 15,
  parameter CW = 4,
  parameter CYCLE_CLKS = `ECD_CYCLE_CLKS
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Machine cycle strobe from the control side (pin)
  input wire cycle_mark,
  // Numbered impulse inputs, bit i is channel i+1
  input wire [CH-1:0] delay_in,
  // Numbered delayed outputs, bit i is channel i+1
  output reg [CH-1:0] delay_out,
  // Operation lengthened while high
  output reg busy
);
  localparam [1:0] S_IDLE = 2'h0; // No stored code
  localparam [1:0] S_DLY1 = 2'h1; // First delay cycle
  localparam [1:0] S_DLY2 = 2'h2; // Second delay cycle
  localparam [1:0] S_EXIT = 2'h3; // Exit cycle
  localparam [31:0] CYC_TOP = CYCLE_CLKS - 1;

  wire [CH-1:0] in_s; // Synchronised inputs
  wire [0:0] mark_s; // Synchronised cycle mark
  reg mark_d_ff; // Previous mark for edge detect
  reg [1:0] state_ff; // Sequence state
  reg [1:0] nxt_state;
  reg [CW-1:0] code_ff; // Latch bits 1,2,4,8
  reg [CW-1:0] nxt_code;
  reg [31:0] tmr_ff; // Machine cycle timer
  reg en_ff; // Unit enable
  reg [CW-1:0] pend_ff; // Code seen in current basic cycle
  reg got_ff; // Any impulse in current basic cycle
  wire [CW-1:0] in_code; // OR of codes of active inputs
  wire [(CH+1)*CW-1:0] or_acc; // Running OR, a zero seed slice then one slice per channel
  wire [CH-1:0] dec_hit; // Channel whose number equals next code
  wire cyc_end; // End of a delay machine cycle
  wire mark_rise; // Start of a new basic cycle
  genvar g; // Channel index

  // Synchronise pins
  ecd_sync #(.W(CH)) u_sync_in (
    .pclk(pclk),
    .presetn(presetn),
    .d(delay_in),
    .q(in_s)
  );
  ecd_sync #(.W(1)) u_sync_mark (
    .pclk(pclk),
    .presetn(presetn),
    .d(cycle_mark),
    .q(mark_s)
  );

  // Per channel: OR its number into the code and decode its output.
  // A running OR chain keeps one driver per slice of the chain.
  assign or_acc[CW-1:0] = {CW{1'b0}};
  generate
    for (g = 0; g < CH; g = g + 1) begin : g_chan
      // Channel number is its index plus one
      wire [31:0] num_w = g + 1;
      wire [CW-1:0] num = num_w[CW-1:0];
      // Inputs that pulse together merge their bit codes
      assign or_acc[(g+1)*CW +: CW] =
        or_acc[g*CW +: CW] | ({CW{in_s[g]}} & num);
      // Only the channel matching the merged code may fire
      assign dec_hit[g] = (nxt_code == num);
    end
  endgenerate
  assign in_code = or_acc[CH*CW +: CW];

  // Mark edge: impulses of the ending basic cycle are complete
  assign mark_rise = mark_s[0] & ~mark_d_ff;
  // Timer end closes one machine cycle of the delay sequence
  assign cyc_end = (tmr_ff == CYC_TOP);

  // Collect impulses during the basic cycle, hand over at its end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mark_d_ff <= 1'b0;
      pend_ff <= {CW{1'b0}};
      got_ff <= 1'b0;
    end else begin
      mark_d_ff <= mark_s[0];
      if (mark_rise && state_ff == S_IDLE) begin
        // Test impulse has ended with the basic cycle
        pend_ff <= en_ff ? (in_s != 0 ? in_code : {CW{1'b0}})
                         : {CW{1'b0}};
        got_ff <= en_ff & (in_s != 0);
      end else if (state_ff == S_IDLE && en_ff && in_s != 0) begin
        pend_ff <= pend_ff | in_code;
        got_ff <= 1'b1;
      end
      // Code handed to the latch bits; start a fresh collection
      if (state_ff == S_IDLE && mark_rise && got_ff) begin
        pend_ff <= {CW{1'b0}};
        got_ff <= 1'b0;
      end
    end
  end

  // Delay sequence: two idle cycles then the exit cycle
  always @* begin
    nxt_state = state_ff;
    nxt_code = code_ff;
    case (state_ff)
      S_IDLE: begin
        if (mark_rise && got_ff) begin
          nxt_state = S_DLY1;
          nxt_code = pend_ff;
        end
      end
      S_DLY1: begin
        if (cyc_end) begin
          nxt_state = S_DLY2;
        end
      end
      S_DLY2: begin
        if (cyc_end) begin
          nxt_state = S_EXIT;
        end
      end
      S_EXIT: begin
        if (cyc_end) begin
          nxt_state = S_IDLE;
          nxt_code = {CW{1'b0}};
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // State, latch bits, timer and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      code_ff <= {CW{1'b0}};
      tmr_ff <= 32'h00000000;
      delay_out <= {CH{1'b0}};
      busy <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
      // Timer restarts on each new delay cycle
      if (state_ff == S_IDLE || cyc_end) begin
        tmr_ff <= 32'h00000000;
      end else begin
        tmr_ff <= tmr_ff + 32'h00000001;
      end
      busy <= (nxt_state != S_IDLE);
      // Decode merged code onto one output in the exit cycle only;
      // the exit starts two cycles after the impulse ended, so a
      // selector switched by it never cuts a test impulse
      if (nxt_state == S_EXIT) begin
        delay_out <= dec_hit;
      end else begin
        delay_out <= {CH{1'b0}};
      end
    end
  end

  // APB slave, zero wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= `ECD_CTRL_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Answer in the access phase that follows each setup cycle;
      // ready and error stand for exactly one cycle; data holds until the next setup cycle
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        case (paddr)
          `ECD_CTRL_OFF: begin
            if (pwrite) begin
              en_ff <= pwdata[`ECD_CTRL_EN_BIT];
            end else begin
              prdata[`ECD_CTRL_EN_BIT] <= en_ff;
            end
          end
          `ECD_STAT_OFF: begin
            prdata[`ECD_STAT_BUSY_BIT] <= busy;
            prdata[`ECD_STAT_PHASE_LSB+1:`ECD_STAT_PHASE_LSB] <= state_ff;
            prdata[`ECD_STAT_CODE_LSB+CW-1:`ECD_STAT_CODE_LSB] <= code_ff;
          end
          `ECD_PEND_OFF: begin
            prdata[CW-1:0] <= pend_ff;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

/* File: verif/ecd_top_properties.sv */
`timescale 1ns/1ns
// Watches the exit pulse and bus answer at the top ports
module ecd_chk #(parameter CH = 15) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire [CH-1:0] delay_out,
  input wire busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Any exit output active
  wire fire = |delay_out;
  a_exit_onehot: assert property (fire |-> $onehot(delay_out) && busy)
    else $error("exit not one-hot or not busy");
  a_idle_delay: assert property ($rose(busy) |-> !fire [*8])
    else $error("output during delay cycles");
  a_exit_soon: assert property ($rose(busy) |-> ##[15:25] fire)
    else $error("exit cycle late");
  a_exit_len: assert property ($rose(fire) |-> fire [*8])
    else $error("exit pulse short");
  a_exit_stable: assert property ($rose(fire) |=> $stable(delay_out) [*8])
    else $error("exit channel changed");
  a_exit_end: assert property ($fell(fire) |-> !busy)
    else $error("busy outlives exit");
  a_busy_hold: assert property ($rose(busy) |-> busy [*8])
    else $error("busy dropped early");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  cover property ($rose(fire));
  cover property ($rose(busy));
  cover property (pready);
endmodule
bind ecd_top ecd_chk #(.CH(CH)) u_chk(.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready),
  .delay_out(delay_out), .busy(busy));

/* File: verif/ecd_wiring.sv */
`timescale 1ns/1ns
// Control wiring: machine cycle strobe and impulses
module ecd_wiring #(parameter P = 10) (
  input wire pclk,
  input wire presetn,
  input wire [14:0] mask,
  input wire [14:0] delay_out,
  output reg cycle_mark,
  output reg [14:0] delay_in,
  output reg sel_xfer
);
  reg [3:0] cnt_ff;
  // Strobe once per cycle, impulse mid-cycle only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      cycle_mark <= 1'b0;
      delay_in <= 15'h0;
    end else begin
      cnt_ff <= (cnt_ff == P - 1) ? 4'h0 : cnt_ff + 4'h1;
      cycle_mark <= (cnt_ff == 4'h0);
      // Routed only into the delay unit
      delay_in <= (cnt_ff > 1 && cnt_ff < 7) ? mask : 15'h0;
    end
  end
  // Latch selector: output 1 picks it up, output 2 drops it out;
  // the common stays on the transferred side in between
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_xfer <= 1'b0;
    end else if (delay_out[0]) begin
      sel_xfer <= 1'b1;
    end else if (delay_out[1]) begin
      sel_xfer <= 1'b0;
    end
  end
endmodule

/* File: verif/ecd_top_tb.sv */
`timescale 1ns/1ns
module ecd_top_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se, en = 1;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [14:0] mask = 0, last = 0;
  reg [14:0] q[$];
  wire [31:0] prdata;
  wire pready, pslverr, cycle_mark, busy, sel_xfer;
  wire [14:0] delay_in, delay_out;
  integer errors = 0, n_checks = 0, i;
  initial forever #5 pclk = ~pclk;
  ecd_top #(.CYCLE_CLKS(10)) ecd_top_inst(.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cycle_mark, .delay_in, .delay_out, .busy);
  ecd_wiring ecd_wiring_inst(.pclk, .presetn, .mask, .cycle_mark,
    .delay_in, .delay_out, .sel_xfer);
  task chk(input [31:0] s, input [31:0] e); begin
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  end endtask
  task tally_and_finish; begin
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask
  // One APB transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d); integer k; begin
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1 && k < 20);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      chk(0, 1);
      tally_and_finish;
    end else begin
      // Let an edge pass so a following call never re-raises psel at once
      @(posedge pclk);
    end
  end endtask
  // Impulse for one machine cycle, noting the merged exit channel
  task pulse(input [14:0] m); integer k; reg [3:0] c; begin
    c = 0;
    for (k = 0; k < 15; k++) if (m[k]) c = c | 4'(k + 1);
    if (c != 0 && en) q.push_back(15'h1 << (c - 1));
    k = 0;
    while (!cycle_mark && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (!cycle_mark) begin
      chk(0, 1);
      tally_and_finish;
    end else begin
      mask <= m;
      repeat (10) @(posedge pclk);
      mask <= 0;
      repeat (50) @(posedge pclk);
      $display("pulse %h done", m);
    end
  end endtask
  // Compare each new exit pulse with the oldest note
  always @(posedge pclk) begin
    if (delay_out !== 0 && last === 0) begin
      chk(delay_in, 0);
      if (q.size() > 0) chk(delay_out, q.pop_front());
      else chk(delay_out, 0);
    end
    last <= delay_out;
  end
  initial begin
    i = $urandom(32'h2e8fcc07);
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    chk(rd, 32'h1);
    apb(0, 12'h004, 0);
    chk(rd, 32'h0);
    apb(0, 12'h008, 0);
    chk(rd, 32'h0);
    apb(0, 12'h0FC, 0);
    chk(se, 1);
    pulse(15'h0004);
    pulse(15'h000C);
    pulse(15'h0006);
    for (i = 0; i < 15; i++) pulse(15'h1 << i);
    pulse(15'h0001);
    chk(sel_xfer, 1);
    pulse(15'h0002);
    chk(sel_xfer, 0);
    for (i = 0; i < 4; i++) pulse(15'($urandom));
    apb(1, 12'h000, 0);
    en = 0;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0);
    pulse(15'h0010);
    apb(1, 12'h000, 1); en = 1;
    pulse(15'h4000);
    chk(q.size(), 0);
    tally_and_finish;
  end
endmodule
